/* rip_pkg.sv */
package rip_pkg;
   // geometry of the port
   localparam int unsigned RIP_ADDR_W   = 5;
   localparam int unsigned RIP_DATA_W   = 8;
   localparam int unsigned RIP_CHANNELS = 8;
   localparam int unsigned RIP_ID_W     = 4;
   // byte offsets from the base address
   localparam logic [4:0] RIP_OFS_RELAY   = 5'h00;
   localparam logic [4:0] RIP_OFS_INPUT   = 5'h01;
   localparam logic [4:0] RIP_OFS_BOARD   = 5'h02;
   localparam logic [4:0] RIP_OFS_IRQ_EN  = 5'h03;
   localparam logic [4:0] RIP_OFS_IRQ_EDG = 5'h04;
   localparam logic [4:0] RIP_OFS_IRQ_FLG = 5'h05;
   // reset values
   localparam logic [7:0] RIP_RST_RELAY   = 8'h00;
   localparam logic [7:0] RIP_RST_IRQ_EN  = 8'h00;
   localparam logic [7:0] RIP_RST_IRQ_EDG = 8'h00;
   localparam logic [7:0] RIP_RST_IRQ_FLG = 8'h00;
   localparam logic [7:0] RIP_RD_ZERO     = 8'h00;
   // edge select encoding
   localparam logic       RIP_EDGE_RISE   = 1'b0;
   localparam logic       RIP_EDGE_FALL   = 1'b1;

   // one host i/o cycle request
   typedef struct packed
   {
      logic       rd;
      logic       wr;
      logic [4:0] addr;
      logic [7:0] wdata;
   } rip_req_s;
endpackage

/* rip_port.sv */
`timescale 1ns/1ps
// Overview of operation
// - decode 32 byte addresses from base
// - write offset 0 loads relay drive bits
// - read offset 0 returns relay drive bits
// - relay bits clear at reset
// - bit 0 normally closed, 1 normally open
// - read offset 1 returns input levels
// - offset 3 holds per-channel irq enables
// - offset 4 edge select: 0 rise, 1 fall
// - read offset 5 returns pending flags
// - writing one at offset 5 clears flag
// - eight independent channel interrupt sources
module rip_port
   import rip_pkg::*;
#(
   parameter int unsigned CHANNELS = RIP_CHANNELS
)
(
   input  wire logic                  ref_clk_i,
   input  wire logic                  nrst_i,
   input  wire logic                  sel_i,
   input  wire rip_req_s              req_i,
   output logic [RIP_DATA_W-1:0]      rdata_o,
   input  wire logic [CHANNELS-1:0]   field_in_i,
   input  wire logic [RIP_ID_W-1:0]   board_ident_i,
   output logic [CHANNELS-1:0]        relay_drive_bit_o,
   output logic                       irq_o
);

   // register and bus logic is byte wide, one bit per channel; the id
   // straps must fit below the data width for the zero-extended read
   if (CHANNELS != RIP_DATA_W)
   begin : g_bad_channels
      $error("rip_port: CHANNELS must equal the data width");
   end
   if (RIP_ID_W > RIP_DATA_W)
   begin : g_bad_ident
      $error("rip_port: board id wider than the data bus");
   end

   logic                  rst_meta;
   logic                  rst_sync_n;
   logic [CHANNELS-1:0]   in_meta;
   logic [CHANNELS-1:0]   in_sync;
   logic [CHANNELS-1:0]   in_prev;
   logic [RIP_ID_W-1:0]   id_meta;
   logic [RIP_ID_W-1:0]   id_sync;
   logic [CHANNELS-1:0]   channel_irq_enable;
   logic [CHANNELS-1:0]   channel_edge_select;
   logic [CHANNELS-1:0]   channel_irq_pending;
   logic [CHANNELS-1:0]   edge_hit;
   logic [CHANNELS-1:0]   next_pending;
   logic [RIP_DATA_W-1:0] next_rdata;
   logic                  wr_relay;
   logic                  wr_en;
   logic                  wr_edge;
   logic                  wr_clr;
   logic                  host_rd;
   logic                  host_wr;
   logic [RIP_DATA_W-1:0] ident_word;
   logic                  irq_any;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // field inputs and id straps come from outside, so two flops each;
   // both stages reset low, so a pin already high at release looks like
   // a rising edge, harmless because every enable also resets to zero
   always_ff @(posedge ref_clk_i or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         in_meta <= '0;
         in_sync <= '0;
         in_prev <= '0;
         id_meta <= '0;
         id_sync <= '0;
      end
      else
      begin
         in_meta <= field_in_i;
         in_sync <= in_meta;
         in_prev <= in_sync;
         id_meta <= board_ident_i;
         id_sync <= id_meta;
      end
   end

   // the host has matched the base already, so only the five offset
   // bits are decoded here; one qualified strobe per direction
   assign host_rd = sel_i && req_i.rd;
   assign host_wr = sel_i && req_i.wr;

   // write strobes; all 32 offsets are claimed, unused ones sink writes
   assign wr_relay = host_wr && (req_i.addr == RIP_OFS_RELAY);
   assign wr_en    = host_wr && (req_i.addr == RIP_OFS_IRQ_EN);
   assign wr_edge  = host_wr && (req_i.addr == RIP_OFS_IRQ_EDG);
   assign wr_clr   = host_wr && (req_i.addr == RIP_OFS_IRQ_FLG);

   // relay coil drive; a 1 moves common to the normally open contact
   // readback is the drive bit; the contacts settle milliseconds later
   always_ff @(posedge ref_clk_i or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         relay_drive_bit_o <= RIP_RST_RELAY;
      else if (wr_relay)
         relay_drive_bit_o <= req_i.wdata;
   end

   // interrupt enable and edge select, read back unchanged
   // both reset to zero, so no channel can flag before it is set up
   always_ff @(posedge ref_clk_i or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         channel_irq_enable  <= RIP_RST_IRQ_EN;
         channel_edge_select <= RIP_RST_IRQ_EDG;
      end
      else
      begin
         if (wr_en)
            channel_irq_enable <= req_i.wdata;
         if (wr_edge)
            channel_edge_select <= req_i.wdata;
      end
   end

   // per-channel edge detect on the synchronised input
   // against its own copy one cycle older
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++)
      begin : g_chan
         always_comb
         begin
            if (channel_edge_select[ch] == RIP_EDGE_FALL)
               edge_hit[ch] = in_prev[ch] && !in_sync[ch];
            else
               edge_hit[ch] = !in_prev[ch] && in_sync[ch];
         end
         // set beats clear so an edge during the clear write is kept
         always_comb
         begin
            next_pending[ch] = channel_irq_pending[ch];
            if (wr_clr && req_i.wdata[ch])
               next_pending[ch] = 1'b0;
            if (channel_irq_enable[ch] && edge_hit[ch])
               next_pending[ch] = 1'b1;
         end
      end
   endgenerate

   // pending flags hold until software writes one; a held flag is
   // not re-reported, which is why software must clear it first
   always_ff @(posedge ref_clk_i or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         channel_irq_pending <= RIP_RST_IRQ_FLG;
      else
         channel_irq_pending <= next_pending;
   end

   // any flag whose channel is still enabled asks for service; a
   // change of enable reaches the request line one cycle later
   assign irq_any = |(next_pending & channel_irq_enable);

   // request line while any enabled flag is pending
   always_ff @(posedge ref_clk_i or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         irq_o <= 1'b0;
      else
         irq_o <= irq_any;
   end

   // straps sit in the low bits; the upper bits read as zero
   assign ident_word = {{(RIP_DATA_W-RIP_ID_W){1'b0}}, id_sync};

   // read mux over the full 32-byte window
   always_comb
   begin
      next_rdata = RIP_RD_ZERO;
      case (req_i.addr)
         RIP_OFS_RELAY:   next_rdata = relay_drive_bit_o;
         RIP_OFS_INPUT:   next_rdata = in_sync;
         RIP_OFS_BOARD:   next_rdata = ident_word;
         RIP_OFS_IRQ_EN:  next_rdata = channel_irq_enable;
         RIP_OFS_IRQ_EDG: next_rdata = channel_edge_select;
         RIP_OFS_IRQ_FLG: next_rdata = channel_irq_pending;
         default:         next_rdata = RIP_RD_ZERO;
      endcase
   end

   // registered read data, one cycle after the read strobe
   // zero when idle, so several ports may be or-ed onto one bus
   always_ff @(posedge ref_clk_i or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         rdata_o <= RIP_RD_ZERO;
      else if (host_rd)
         rdata_o <= next_rdata;
      else
         rdata_o <= RIP_RD_ZERO;
   end

endmodule

/* rip_port_properties.sv */
`timescale 1ns/1ps
module rip_port_checker
   import rip_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       sel_i,
   input  wire rip_req_s   req_i,
   input  wire logic [7:0] rdata_o,
   input  wire logic [7:0] relay_drive_bit_o,
   input  wire logic       irq_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   // decoded strobes; only the low five address bits reach the port
   wire rd = sel_i && req_i.rd;
   wire wr = sel_i && req_i.wr;
   wire wr_relay = wr && req_i.addr == RIP_OFS_RELAY;
   a_relay_write: assert property (wr_relay
      |=> relay_drive_bit_o == $past(req_i.wdata)) else $error("relay load");
   a_relay_hold: assert property (!wr_relay
      |=> $stable(relay_drive_bit_o)) else $error("relay moved");
   a_relay_read: assert property (rd && req_i.addr == RIP_OFS_RELAY
      |=> rdata_o == $past(relay_drive_bit_o)) else $error("relay read");
   a_rdata_idle: assert property (!rd |=> rdata_o == 8'h00)
      else $error("rdata not idle");
   a_unused_read: assert property (rd && req_i.addr > 5'h05
      |=> rdata_o == 8'h00) else $error("unused offset read");
   a_ident_upper: assert property (rd && req_i.addr == RIP_OFS_BOARD
      |=> rdata_o[7:4] == 4'h0) else $error("ident upper bits");
   a_irq_disable: assert property (wr && req_i.addr == RIP_OFS_IRQ_EN
      && req_i.wdata == 8'h00 |-> ##[1:2] !irq_o) else $error("irq stuck");
   a_reset_zero: assert property (disable iff (1'b0) !nrst_i
      |-> relay_drive_bit_o == 8'h00 && !irq_o) else $error("reset value");
endmodule
bind rip_port rip_port_checker rip_port_checker_inst (.*);

/* rip_field.sv */
`timescale 1ns/1ps
// field side: the opto stage adds one cycle of delay before the pin
module rip_field
(
   input  wire logic       ref_clk_i,
   input  wire logic [7:0] level_i,
   output logic [7:0]      field_o
);
   always_ff @(posedge ref_clk_i)
   begin
      field_o <= level_i;
   end
endmodule

/* rip_port_bench.sv */
`timescale 1ns/1ps
module rip_port_bench
   import rip_pkg::*;
;
   logic       ref_clk_i = 1'b0;
   logic       nrst_i;
   logic       sel_i = 1'b0;
   rip_req_s   req_i = '0;
   logic [7:0] level = 8'hf0;
   logic [3:0] ident = 4'h9;
   logic [7:0] field, rdata, relay;
   logic       irq;
   int         n_errors = 0;
   int         cmp_count = 0;
   always #50 ref_clk_i = ~ref_clk_i;
   rip_field rip_field_inst (.ref_clk_i(ref_clk_i), .level_i(level),
      .field_o(field));
   rip_port rip_port_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .sel_i(sel_i), .req_i(req_i), .rdata_o(rdata), .field_in_i(field),
      .board_ident_i(ident), .relay_drive_bit_o(relay), .irq_o(irq));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one-cycle pulse, request launched just after an edge
   task acc(input logic r, input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      sel_i <= 1'b1;
      req_i <= '{rd: r, wr: !r, addr: a, wdata: d};
      @(posedge ref_clk_i);
      sel_i <= 1'b0;
      req_i <= '0;
      #1;
   endtask
   task rd(input logic [4:0] a, input logic [7:0] exp);
      acc(1'b1, a, 8'h00);
      chk(rdata, exp);
   endtask
   task wrap_up();
      if (n_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // watchdog at 2000 cycles, well beyond the fewer than one hundred cycles the tests need
   initial
   begin
      #200000;
      n_errors++;
      wrap_up();
   end
   initial
   begin
      nrst_i <= 1'b0; // a real falling edge fires the async reset
      repeat (2) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      rd(5'h00, 8'h00);
      acc(1'b0, 5'h00, 8'ha5);
      chk(relay, 8'ha5);
      rd(5'h00, 8'ha5);
      acc(1'b0, 5'h01, 8'hff);
      acc(1'b0, 5'h02, 8'hff);
      rd(5'h00, 8'ha5);
      rd(5'h06, 8'h00);
      rd(5'h1f, 8'h00);
      rd(5'h01, 8'hf0);
      rd(5'h02, 8'h09);
      acc(1'b0, 5'h05, 8'hff);
      acc(1'b0, 5'h03, 8'h7f);
      acc(1'b0, 5'h04, 8'hf0);
      rd(5'h03, 8'h7f);
      rd(5'h04, 8'hf0);
      rd(5'h05, 8'h00);
      // low nibble rises, high nibble falls; channel 7 stays disabled
      level <= 8'h0f;
      repeat (6) @(posedge ref_clk_i);
      rd(5'h05, 8'h7f);
      chk({7'h00, irq}, 8'h01);
      acc(1'b0, 5'h05, 8'h05);
      rd(5'h05, 8'h7a);
      acc(1'b0, 5'h05, 8'hff);
      chk({7'h00, irq}, 8'h00);
      // opposite edges on every channel must not set a flag
      level <= 8'hf0;
      repeat (6) @(posedge ref_clk_i);
      rd(5'h05, 8'h00);
      // re-arm so flags stand, then drop every enable under them
      level <= 8'h0f;
      repeat (6) @(posedge ref_clk_i);
      chk({7'h00, irq}, 8'h01);
      acc(1'b0, 5'h03, 8'h00);
      rd(5'h05, 8'h7f);
      chk({7'h00, irq}, 8'h00);
      wrap_up();
   end
endmodule
